// [logic/mvo_top.sv]
// Top of the motor and valve output controller: registers, output sequencing and interlocks.
//
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/1ns
module mvo_top #(
    parameter int TICK_CYCLES = mvo_pkg::TICK_CYCLES
) (
    // Clock and reset.
    input  wire logic                                         sys_clk,
    input  wire logic                                         arst_n,
    // Register port.
    input  wire logic [7:0]                                   reg_addr,
    input  wire logic [31:0]                                  reg_wdata,
    input  wire logic                                         reg_wr,
    input  wire logic                                         reg_rd,
    output logic [31:0]                                       reg_rdata,
    // Measurements and driver faults.
    input  wire logic [mvo_pkg::NUM_FUNC*mvo_pkg::AMP_W-1:0]  fn_current_amps,
    input  wire logic [mvo_pkg::NUM_VALVE-1:0]                valve_hot_pin,
    // Function relays.
    output logic [mvo_pkg::NUM_FUNC*4-1:0]                    fn_term,
    output logic [mvo_pkg::NUM_FUNC*2-1:0]                    fuse_select,
    output logic [mvo_pkg::NUM_FUNC-1:0]                      fuse_connect,
    // Valve drivers.
    output logic [mvo_pkg::NUM_VALVE-1:0]                     valve_drive,
    output logic [mvo_pkg::NUM_VALVE-1:0]                     valve_oe_n,
    // Manual switch supply.
    output logic                                              manual_switch_supply_pos,
    output logic                                              manual_switch_supply_neg,
    // Interrupt.
    output logic                                              irq
);

    // ************************************************************
    // State.
    // ************************************************************
    typedef struct packed {
        logic [mvo_pkg::NUM_FUNC-1:0][mvo_pkg::CMD_W-1:0]   cmd;
        logic [mvo_pkg::NUM_FUNC-1:0][mvo_pkg::FUSE_W-1:0]  fuse;
        logic [2:0]                                         pump;
        logic [mvo_pkg::IRQ_W-1:0]                          irq_stat;
        logic [mvo_pkg::IRQ_W-1:0]                          irq_en;
        logic [31:0]                                        rdata;
        logic [mvo_pkg::NUM_FUNC-1:0][mvo_pkg::PARK_W-1:0]  park;
        logic [mvo_pkg::NUM_FUNC-1:0]                       was_active;
        logic [mvo_pkg::NUM_VALVE-1:0]                      hot_meta;
        logic [mvo_pkg::NUM_VALVE-1:0]                      hot_sync;
        logic [mvo_pkg::NUM_FUNC-1:0][3:0]                  term;
        logic [mvo_pkg::NUM_VALVE-1:0]                      valve;
        logic                                               msw_closed;
        logic                                               irq;
    } mvo_top_type;

    mvo_top_type                    s;
    mvo_top_type                    next_s;
    logic                           tick_ms;
    logic [mvo_pkg::NUM_FUNC-1:0]   fn_request;
    logic [mvo_pkg::NUM_FUNC-1:0]   fn_fuse_ok;
    logic [mvo_pkg::NUM_FUNC-1:0]   ch_run;
    logic [mvo_pkg::NUM_FUNC-1:0]   ch_cool;
    logic [mvo_pkg::NUM_FUNC-1:0]   ch_trip;
    logic [mvo_pkg::NUM_FUNC-1:0]   fn_active;
    logic [mvo_pkg::NUM_FUNC-1:0]   stop_written;
    logic [mvo_pkg::NUM_VALVE-1:0]  valve_want;
    logic [mvo_pkg::NUM_VALVE-1:0]  hot_event;
    logic [mvo_pkg::IRQ_W-1:0]      irq_clear;
    logic                           pump_ext;
    logic                           pump_ret;

    // ************************************************************
    // Time base and per-function guards.
    // ************************************************************
    mvo_tick #(
        .CYCLES (TICK_CYCLES)
    ) u_tick (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .tick    (tick_ms)
    );

    // One guard per function output, each with its own timers.
    for (genvar f = 0; f < mvo_pkg::NUM_FUNC; f++) begin : g_chan
        mvo_chan u_chan (
            .sys_clk   (sys_clk),
            .arst_n    (arst_n),
            .tick_ms   (tick_ms),
            .fuse_ok   (fn_fuse_ok[f]),
            .request   (fn_request[f]),
            .load_amps (fn_current_amps[f*mvo_pkg::AMP_W +: mvo_pkg::AMP_W]),
            .run       (ch_run[f]),
            .cooling   (ch_cool[f]),
            .trip      (ch_trip[f])
        );
    end

    // ************************************************************
    // Function activity.
    // ************************************************************

    // A function drives only with a drive command, a fuse and a guard that allows it.
    always_comb begin
        for (int f = 0; f < mvo_pkg::NUM_FUNC; f++) begin
            fn_request[f] = mvo_pkg::mvo_cmd_drives(s.cmd[f]);
            fn_fuse_ok[f] = mvo_pkg::mvo_fuse_valid(s.fuse[f]);
            fn_active[f]  = fn_request[f] && fn_fuse_ok[f] && ch_run[f];
            stop_written[f] = reg_wr && (reg_addr == mvo_pkg::REG_CMD)
                && (reg_wdata[f*mvo_pkg::CMD_W +: mvo_pkg::CMD_W] == mvo_pkg::CMD_STOP);
        end
    end

    // Pump direction and the valves that follow their functions.
    always_comb begin
        pump_ext = (s.pump[mvo_pkg::CMD_W-1:0] == mvo_pkg::CMD_EXTEND);
        pump_ret = (s.pump[mvo_pkg::CMD_W-1:0] == mvo_pkg::CMD_RETRACT);
        valve_want = '0;
        for (int v = 0; v < mvo_pkg::FN_VALVES; v++) begin
            valve_want[mvo_pkg::VALVE_OUT_ONE + v] = fn_active[v];
        end
        // One of the two shared valves, picked by the pump select bit, rides on whichever pump direction is commanded.
        valve_want[mvo_pkg::SHARED_VALVE_A] = (pump_ext || pump_ret) && !s.pump[mvo_pkg::PUMP_SEL_BIT];
        valve_want[mvo_pkg::SHARED_VALVE_B] = (pump_ext || pump_ret) && s.pump[mvo_pkg::PUMP_SEL_BIT];
        valve_want[mvo_pkg::PUMP_EXTEND]    = pump_ext;
        valve_want[mvo_pkg::PUMP_RETRACT]   = pump_ret;
        hot_event = valve_want & s.hot_sync;
        irq_clear = (reg_wr && (reg_addr == mvo_pkg::REG_IRQ_CLR)) ? reg_wdata[mvo_pkg::IRQ_W-1:0] : '0;
    end

    // ************************************************************
    // Next state.
    // ************************************************************
    always_comb begin
        next_s = s;
        next_s.rdata = 32'h0;

        // Register writes.
        if (reg_wr) begin
            case (reg_addr)
                mvo_pkg::REG_CMD: begin
                    next_s.cmd = reg_wdata[mvo_pkg::NUM_FUNC*mvo_pkg::CMD_W-1:0];
                end
                mvo_pkg::REG_FUSE: begin
                    next_s.fuse = reg_wdata[mvo_pkg::NUM_FUNC*mvo_pkg::FUSE_W-1:0];
                end
                mvo_pkg::REG_PUMP: begin
                    next_s.pump = reg_wdata[2:0];
                end
                mvo_pkg::REG_IRQ_EN: begin
                    next_s.irq_en = reg_wdata[mvo_pkg::IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // Register reads; data stand one cycle after the strobe and unmapped offsets read zero.
        if (reg_rd) begin
            case (reg_addr)
                mvo_pkg::REG_CMD: begin
                    next_s.rdata = 32'(s.cmd);
                end
                mvo_pkg::REG_FUSE: begin
                    next_s.rdata = 32'(s.fuse);
                end
                mvo_pkg::REG_PUMP: begin
                    next_s.rdata = 32'(s.pump);
                end
                mvo_pkg::REG_STATUS: begin
                    next_s.rdata = 32'({ch_cool, fn_active});
                end
                mvo_pkg::REG_IRQ_STAT: begin
                    next_s.rdata = 32'(s.irq_stat);
                end
                mvo_pkg::REG_IRQ_EN: begin
                    next_s.rdata = 32'(s.irq_en);
                end
                default: begin
                    next_s.rdata = 32'h0;
                end
            endcase
        end

        // Sticky events; a new event in the cycle of its clear survives.
        next_s.irq_stat = (s.irq_stat & ~irq_clear) | {hot_event, ch_trip};
        next_s.irq = |(next_s.irq_stat & next_s.irq_en);

        // Thermal fault pins are asynchronous, so they pass two flops first.
        next_s.hot_meta = valve_hot_pin;
        next_s.hot_sync = s.hot_meta;

        // Terminal drive per function: direction while active, brake while parked, else open.
        for (int f = 0; f < mvo_pkg::NUM_FUNC; f++) begin
            next_s.was_active[f] = fn_active[f];
            if (fn_active[f]) begin
                next_s.park[f] = '0;
            end else if (stop_written[f] || s.was_active[f]) begin
                next_s.park[f] = mvo_pkg::PARK_TICKS;
            end else if (tick_ms && (s.park[f] != '0)) begin
                next_s.park[f] = s.park[f] - 1'b1;
            end
            next_s.term[f] = 4'h0;
            if (fn_active[f] && (s.cmd[f] == mvo_pkg::CMD_EXTEND)) begin
                next_s.term[f][mvo_pkg::TERM_POS_BATT] = 1'b1;
                next_s.term[f][mvo_pkg::TERM_NEG_GND] = 1'b1;
            end else if (fn_active[f]) begin
                next_s.term[f][mvo_pkg::TERM_NEG_BATT] = 1'b1;
                next_s.term[f][mvo_pkg::TERM_POS_GND] = 1'b1;
            end else if (next_s.park[f] != '0) begin
                // Both sides to ground stops the motor quickly instead of letting it coast.
                next_s.term[f][mvo_pkg::TERM_POS_GND] = 1'b1;
                next_s.term[f][mvo_pkg::TERM_NEG_GND] = 1'b1;
            end
        end

        // Valves are cut while their driver reports overheating.
        next_s.valve = valve_want & ~s.hot_sync;

        // The supply relay only looks at activity, which includes each guard's run state, so manual switches
        // have power whenever no function is driving.
        next_s.msw_closed = ~|fn_active;
    end

    // State register.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '{msw_closed: 1'b1, default: '0};
        end else begin
            s <= next_s;
        end
    end

    // ************************************************************
    // Outputs.
    // ************************************************************

    // Fuse position codes one to four map onto select values zero to three.
    always_comb begin
        for (int f = 0; f < mvo_pkg::NUM_FUNC; f++) begin
            fuse_select[f*2 +: 2] = fn_fuse_ok[f] ? 2'(s.fuse[f] - 1'b1) : 2'h0;
        end
    end

    assign fuse_connect = fn_fuse_ok;
    assign reg_rdata    = s.rdata;
    assign fn_term      = s.term;

    // An idle valve is released, not pulled low.
    assign valve_drive = s.valve;
    assign valve_oe_n  = ~s.valve;

    assign manual_switch_supply_pos = s.msw_closed;
    assign manual_switch_supply_neg = s.msw_closed;
    assign irq                      = s.irq;

endmodule // mvo_top

// [logic/mvo_pkg.sv]
// Constants, codes and helper functions shared by the motor and valve output controller.
package mvo_pkg;

    // ************************************************************
    // Sizes.
    // ************************************************************
    localparam int NUM_FUNC  = 7;
    localparam int NUM_VALVE = 7;
    localparam int AMP_W     = 8;
    localparam int TIME_W    = 17;
    localparam int PARK_W    = 12;
    localparam int IRQ_W     = NUM_FUNC + NUM_VALVE;
    localparam int FN_VALVES = 3;

    // ************************************************************
    // Timing, with the millisecond tick as the common time base.
    // ************************************************************
    localparam int CLK_PERIOD_NS        = 10;
    localparam int TICK_PERIOD_NS       = 1_000_000;
    localparam int TICK_CYCLES          = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int INRUSH_BLANK_TIME_MS = 80;
    localparam int COOL_DOWN_S          = 30;
    localparam int MAX_ON_MIN           = 2;
    localparam int PARK_TIME_MS         = 3000;
    localparam int THRESH_AMPS          = 29;
    localparam int BUDGET_CENTI_AS      = 12158;
    localparam logic [TIME_W-1:0] INRUSH_TICKS = TIME_W'(INRUSH_BLANK_TIME_MS);
    localparam logic [TIME_W-1:0] COOL_TICKS   = TIME_W'(COOL_DOWN_S * 1000);
    localparam logic [TIME_W-1:0] MAX_ON_TICKS = TIME_W'(MAX_ON_MIN * 60 * 1000);
    localparam logic [TIME_W-1:0] BUDGET_AMS   = TIME_W'(BUDGET_CENTI_AS * 10);
    localparam logic [PARK_W-1:0] PARK_TICKS   = PARK_W'(PARK_TIME_MS);
    localparam logic [AMP_W-1:0]  THRESH       = AMP_W'(THRESH_AMPS);

    // ************************************************************
    // Command and fuse codes.
    // ************************************************************
    localparam int CMD_W  = 2;
    localparam int FUSE_W = 3;
    localparam logic [CMD_W-1:0]  CMD_IDLE    = 2'h0;
    localparam logic [CMD_W-1:0]  CMD_EXTEND  = 2'h1;
    localparam logic [CMD_W-1:0]  CMD_RETRACT = 2'h2;
    localparam logic [CMD_W-1:0]  CMD_STOP    = 2'h3;
    localparam logic [FUSE_W-1:0] FUSE_NONE   = 3'h0;
    localparam logic [FUSE_W-1:0] FUSE_LAST   = 3'h4;

    // ************************************************************
    // Register map and field positions.
    // ************************************************************
    localparam logic [7:0] REG_CMD      = 8'h00;
    localparam logic [7:0] REG_FUSE     = 8'h04;
    localparam logic [7:0] REG_PUMP     = 8'h08;
    localparam logic [7:0] REG_STATUS   = 8'h0c;
    localparam logic [7:0] REG_IRQ_STAT = 8'h10;
    localparam logic [7:0] REG_IRQ_CLR  = 8'h14;
    localparam logic [7:0] REG_IRQ_EN   = 8'h18;
    localparam int PUMP_SEL_BIT = 2;
    localparam int IRQ_HOT_LSB  = NUM_FUNC;

    // ************************************************************
    // Valve and terminal positions.
    // ************************************************************
    localparam int VALVE_OUT_ONE  = 0;
    localparam int SHARED_VALVE_A = 3;
    localparam int SHARED_VALVE_B = 4;
    localparam int PUMP_EXTEND    = 5;
    localparam int PUMP_RETRACT   = 6;
    localparam int TERM_POS_BATT  = 0;
    localparam int TERM_POS_GND   = 1;
    localparam int TERM_NEG_BATT  = 2;
    localparam int TERM_NEG_GND   = 3;

    // ************************************************************
    // Helpers.
    // ************************************************************
    function automatic logic mvo_cmd_drives(input logic [CMD_W-1:0] c);
        return (c == CMD_EXTEND) || (c == CMD_RETRACT);
    endfunction

    function automatic logic mvo_fuse_valid(input logic [FUSE_W-1:0] f);
        return (f != FUSE_NONE) && (f <= FUSE_LAST);
    endfunction

endpackage

// [logic/mvo_tick.sv]
// Divider that makes a one-cycle millisecond enable pulse.
`timescale 1ns/1ns
module mvo_tick #(
    parameter int CYCLES = mvo_pkg::TICK_CYCLES
) (
    // Clock and reset.
    input  wire logic sys_clk,
    input  wire logic arst_n,
    // Enable pulse.
    output logic      tick
);

    typedef struct packed {
        logic [31:0] count;
        logic        tick;
    } mvo_tick_type;

    mvo_tick_type s;
    mvo_tick_type next_s;

    // Count to the period and pulse once per wrap.
    always_comb begin
        next_s = s;
        next_s.tick = 1'b0;
        if (s.count >= 32'(CYCLES - 1)) begin
            next_s.count = 32'h0;
            next_s.tick = 1'b1;
        end else begin
            next_s.count = s.count + 32'h1;
        end
    end

    // State register.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tick = s.tick;

endmodule // mvo_tick

// [logic/mvo_chan.sv]
// Per-function over-current guard with integrated energy, cool-down and re-arm.
`timescale 1ns/1ns
module mvo_chan (
    // Clock and reset.
    input  wire logic                        sys_clk,
    input  wire logic                        arst_n,
    // Time base and request.
    input  wire logic                        tick_ms,
    input  wire logic                        fuse_ok,
    input  wire logic                        request,
    input  wire logic [mvo_pkg::AMP_W-1:0]   load_amps,
    // Status.
    output logic                             run,
    output logic                             cooling,
    output logic                             trip
);

    typedef enum logic [1:0] {CH_IDLE, CH_RUN, CH_COOL, CH_WAIT_RELEASE} mvo_ch_state_type;

    typedef struct packed {
        mvo_ch_state_type                  state;
        logic [mvo_pkg::TIME_W-1:0]        timer;
        logic [mvo_pkg::TIME_W-1:0]        energy;
        logic                              trip;
    } mvo_ch_type;

    mvo_ch_type                 s;
    mvo_ch_type                 next_s;
    logic [mvo_pkg::AMP_W-1:0]  excess;
    logic [mvo_pkg::TIME_W-1:0] timer_inc;
    logic [mvo_pkg::TIME_W-1:0] energy_sum;

    // Each channel keeps its own account, so one trip never blocks another.
    always_comb begin
        next_s = s;
        next_s.trip = 1'b0;
        excess = (load_amps > mvo_pkg::THRESH) ? load_amps - mvo_pkg::THRESH : '0;
        timer_inc = s.timer + 1'b1;
        // Current is only charged once the inrush window has passed.
        energy_sum = (s.timer >= mvo_pkg::INRUSH_TICKS) ? s.energy + mvo_pkg::TIME_W'(excess) : s.energy;
        case (s.state)
            CH_IDLE: begin
                if (request && fuse_ok) begin
                    next_s.state = CH_RUN;
                    next_s.timer = '0;
                    next_s.energy = '0;
                end
            end
            CH_RUN: begin
                if (!request || !fuse_ok) begin
                    next_s.state = CH_IDLE;
                end else if (tick_ms) begin
                    next_s.timer = timer_inc;
                    next_s.energy = energy_sum;
                    // Amp-milliseconds above the threshold against the budget, plus the flat time cap.
                    if (energy_sum >= mvo_pkg::BUDGET_AMS || timer_inc >= mvo_pkg::MAX_ON_TICKS) begin
                        next_s.state = CH_COOL;
                        next_s.timer = '0;
                        next_s.trip = 1'b1;
                    end
                end
            end
            CH_COOL: begin
                // Requests are simply not looked at while cooling.
                if (tick_ms) begin
                    next_s.timer = timer_inc;
                    if (timer_inc >= mvo_pkg::COOL_TICKS) begin
                        next_s.state = CH_WAIT_RELEASE;
                    end
                end
            end
            CH_WAIT_RELEASE: begin
                // A held button must not restart the motor on its own.
                if (!request) begin
                    next_s.state = CH_IDLE;
                end
            end
            default: begin
                next_s.state = CH_IDLE;
            end
        endcase
    end

    // State register.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '{state: CH_IDLE, default: '0};
        end else begin
            s <= next_s;
        end
    end

    assign run     = (s.state == CH_RUN);
    assign cooling = (s.state == CH_COOL);
    assign trip    = s.trip;

endmodule // mvo_chan

// [sim/mvo_load.sv]
// Motor load model that draws its set current while a function is driven.
`timescale 1ns/1ns
module mvo_load (
    // Terminal states and per-function load.
    input  wire logic [27:0] fn_term,
    input  wire logic [55:0] load_amps,
    // Measured current.
    output logic [55:0]      fn_current_amps
);
    // A motor draws nothing unless a terminal sits on battery.
    always_comb begin
        for (int f = 0; f < 7; f++) begin
            fn_current_amps[8*f+:8] = (fn_term[4*f] | fn_term[4*f+2]) ? load_amps[8*f+:8] : 8'h00;
        end
    end
endmodule // mvo_load

// [sim/mvo_sva.sv]
// Port checker of the output controller.
`timescale 1ns/1ns
module mvo_sva (
    input wire logic        sys_clk,
    input wire logic        arst_n,
    input wire logic [6:0]  fuse_connect,
    input wire logic [6:0]  valve_hot_pin,
    input wire logic [27:0] fn_term,
    input wire logic [6:0]  valve_drive,
    input wire logic [6:0]  valve_oe_n,
    input wire logic        manual_switch_supply_pos,
    input wire logic        manual_switch_supply_neg
);
    logic [6:0] drv;
    // A function is active while either terminal is on battery.
    always_comb begin
        for (int f = 0; f < 7; f++) drv[f] = fn_term[4*f] | fn_term[4*f+2];
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    valve_fn_a: assert property (valve_drive[2:0] == drv[2:0])
        else $error("valve differs from function");
    oe_low_a: assert property (valve_oe_n == ~valve_drive)
        else $error("valve enable wrong");
    supply_open_a: assert property (manual_switch_supply_pos == !(|drv))
        else $error("supply interlock wrong");
    supply_pair_a: assert property (manual_switch_supply_pos == manual_switch_supply_neg)
        else $error("supply halves differ");
    no_fuse_a: assert property (!fuse_connect[1] [*3] |-> !drv[1])
        else $error("unfused function driven");
    pump_excl_a: assert property (!(valve_drive[5] && valve_drive[6]))
        else $error("pump both ways");
    brake_a: assert property ($fell(fn_term[0]) && !fn_term[2] |-> fn_term[1] && fn_term[3])
        else $error("no brake after drive");
    hot_cut_a: assert property (valve_hot_pin[4] [*4] |-> !valve_drive[4])
        else $error("hot valve still on");
endmodule // mvo_sva
bind mvo_top mvo_sva chk_i (.sys_clk, .arst_n, .fuse_connect, .valve_hot_pin, .fn_term, .valve_drive,
    .valve_oe_n, .manual_switch_supply_pos, .manual_switch_supply_neg);

// [sim/tb.sv]
// Self-checking bench of the output controller.
`timescale 1ns/1ns
module tb;
    logic sys_clk, arst_n, reg_wr, reg_rd, manual_switch_supply_pos, manual_switch_supply_neg, irq;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [55:0] load_amps, fn_current_amps;
    logic [6:0]  valve_hot_pin, fuse_connect, valve_drive, valve_oe_n;
    logic [27:0] fn_term;
    logic [13:0] fuse_select;
    int n_fail, comparisons, n, e;
    // A short tick keeps the cool-down inside the run.
    mvo_top #(.TICK_CYCLES(2)) uut (.sys_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .fn_current_amps, .valve_hot_pin, .fn_term, .fuse_select, .fuse_connect, .valve_drive, .valve_oe_n,
        .manual_switch_supply_pos, .manual_switch_supply_neg, .irq);
    mvo_load load_i (.fn_term, .load_amps, .fn_current_amps);
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Sampling 1 ns after the edge keeps checks clear of the edge's own updates.
    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
        cyc(1);
        reg_wr <= 1'b0;
        cyc(1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        reg_addr <= a; reg_rd <= 1'b1;
        cyc(1);
        chk(reg_rdata, x);
        // Letting one edge pass keeps back-to-back reads from driving the strobe twice at once.
        reg_rd <= 1'b0;
        cyc(1);
    endtask
    task automatic t_drive;
        wr(8'h04, 32'hb01);
        chk(fuse_connect, 7'h05);
        chk(fuse_select, 14'h0030);
        wr(8'h00, 32'h65);
        cyc(2);
        chk(fn_term[15:0], 16'h0609);
        chk(valve_drive[2:0], 3'h5);
        chk({manual_switch_supply_pos, manual_switch_supply_neg}, 2'h0);
        rd(8'h0c, 32'h5);
        rd(8'h40, 32'h0);
        wr(8'h00, 32'h33);
        cyc(2);
        chk(fn_term[11:0], 12'ha0a);
        cyc(6100);
        chk(fn_term[11:0], 12'h000);
        chk({manual_switch_supply_pos, manual_switch_supply_neg}, 2'h3);
    endtask
    task automatic t_pump;
        wr(8'h08, 32'h1);
        cyc(2);
        chk(valve_drive[6:3], 4'h5);
        wr(8'h08, 32'h6);
        cyc(2);
        chk(valve_drive[6:3], 4'ha);
        wr(8'h18, 32'h3fff);
        valve_hot_pin <= 7'h10;
        cyc(5);
        chk({irq, valve_drive[4]}, 2'h2);
        wr(8'h08, 32'h0);
        valve_hot_pin <= 7'h00;
        cyc(4);
        wr(8'h14, 32'h800);
        cyc(2);
        chk(irq, 1'b0);
    endtask
    task automatic t_trip;
        load_amps <= 56'h0a00ff;
        wr(8'h00, 32'h21);
        e = 2 * (mvo_pkg::INRUSH_BLANK_TIME_MS + (mvo_pkg::BUDGET_CENTI_AS * 10 + 225) / 226);
        // The terminals only start driving one edge after the write returns.
        cyc(1);
        for (n = 0; n < 2000 && fn_term[0]; n++) cyc(1);
        if (n == 2000) begin n_fail++; end_sim; end
        chk(n > e - 20 && n < e + 20, 1'b1);
        rd(8'h10, 32'h1);
        rd(8'h0c, 32'h84);
        wr(8'h00, 32'h21);
        cyc(3);
        chk(fn_term[11:0], 12'h60a);
        load_amps <= 56'h0;
        cyc(60100);
        chk(fn_term[0], 1'b0);
        wr(8'h00, 32'h20);
        wr(8'h00, 32'h21);
        cyc(1);
        chk(fn_term[3:0], 4'h9);
    endtask
    // Main sequence: reset, then each scenario in turn.
    initial begin
        arst_n = 0; reg_wr = 0; reg_rd = 0; reg_addr = 0; reg_wdata = 0;
        load_amps = 0; valve_hot_pin = 0; n_fail = 0; comparisons = 0;
        cyc(12);
        chk({manual_switch_supply_pos, manual_switch_supply_neg, valve_oe_n, irq}, 10'h3fe);
        chk(fn_term, 28'h0);
        arst_n <= 1'b1;
        cyc(1);
        t_drive;
        t_pump;
        t_trip;
        end_sim;
    end
endmodule // tb
